// file: wsc_pkg.sv
// Shared types and constants of the word-serial configuration command decoder
`default_nettype none
package wsc_pkg;
	typedef enum logic [1:0] {
		OP_ABORT_NORMAL,
		OP_ASSIGN_IRQ,
		OP_ASYNC_MODE,
		OP_BEGIN_NORMAL
	} wsc_op_e;

	typedef enum logic {
		SUB_CONFIGURE,
		SUB_NORMAL
	} wsc_sub_e;

	localparam int           ARG_W          = 16;
	localparam int           IRQ_LINE_W     = 3;
	localparam int           TOP_LEVEL_BIT  = 8;
	localparam int           ERR_W          = 4;

	// Asynchronous mode argument: only events-as-interrupts is accepted
	localparam logic [15:0]  ASYNC_MASK     = 16'h000F;
	localparam logic [15:0]  ASYNC_EV_INT   = 16'h0008;

	localparam logic [3:0]   ERR_NONE       = 4'h0;
	localparam logic [3:0]   ERR_ASYNC      = 4'h1;
	localparam logic [3:0]   ERR_STATE      = 4'h7;

	localparam logic [2:0]   RST_IRQ_LINE   = 3'h0;
	localparam logic         RST_EV_INT     = 1'b0;
	localparam logic         RST_TOP_LEVEL  = 1'b0;

	typedef struct packed {
		wsc_op_e            op;
		logic [ARG_W-1:0]   arg;
	} wsc_cmd_s;

	typedef struct packed {
		logic               done;
		logic               err;
		logic [ERR_W-1:0]   code;
	} wsc_rsp_s;
endpackage : wsc_pkg
`default_nettype wire

// file: wsc_config_cmd.sv
// Word-serial configuration command decoder with substate, IRQ line and top-level flag
//
// How it works
// - Abort in Configure restores power-up default configuration
// - Interrupt request deasserted after abort
// - Assign-interrupter command stores IRQ line selection
// - Line resets to zero; zero means no interrupts
// - Only events-as-interrupts accepted; others flag error
// - Begin-normal in Configure enters Normal Operation
// - Entering Normal sets word-serial readiness flags
// - Bit 8 of begin-normal captured as top-level
`default_nettype none
module wsc_config_cmd (
	input  wire logic                           core_clk_i,
	input  wire logic                           sys_rst_i,
	input  wire logic                           cmd_valid_i,
	input  wire wsc_pkg::wsc_cmd_s              cmd_i,
	input  wire logic                           event_i,
	input  wire logic                           irq_ack_i,
	output logic                                done_o,
	output logic                                err_o,
	output logic [wsc_pkg::ERR_W-1:0]           err_code_o,
	output logic                                normal_o,
	output logic                                ws_ready_o,
	output logic [wsc_pkg::IRQ_LINE_W-1:0]      irq_line_o,
	output logic                                ev_int_o,
	output logic                                top_level_o,
	output logic                                irq_o
);
	wsc_pkg::wsc_sub_e                      sub_ff, nxt_sub;
	wsc_pkg::wsc_rsp_s                      rsp_ff, nxt_rsp;
	logic [wsc_pkg::IRQ_LINE_W-1:0]         line_ff, nxt_line;
	logic                                   ev_int_ff, nxt_ev_int;
	logic                                   top_ff, nxt_top;
	logic                                   ready_ff, nxt_ready;
	logic                                   irq_ff, nxt_irq;
	logic                                   abort_now;
	logic                                   async_hit;

	function automatic logic async_ok(input logic [wsc_pkg::ARG_W-1:0] arg);
		return (arg & wsc_pkg::ASYNC_MASK) == wsc_pkg::ASYNC_EV_INT;
	endfunction

	// Shared by the decoder and its assertion so both judge the same argument
	assign async_hit = async_ok(cmd_i.arg);

	// Command decode and configuration state
	always_comb begin
		nxt_sub    = sub_ff;
		nxt_line   = line_ff;
		nxt_ev_int = ev_int_ff;
		nxt_top    = top_ff;
		nxt_ready  = ready_ff;
		nxt_rsp    = '0;
		abort_now  = 1'b0;
		if (cmd_valid_i) begin
			nxt_rsp.done = 1'b1;
			if (sub_ff == wsc_pkg::SUB_NORMAL) begin
				nxt_rsp.err  = 1'b1;
				nxt_rsp.code = wsc_pkg::ERR_STATE;
			end else begin
				case (cmd_i.op)
					wsc_pkg::OP_ABORT_NORMAL: begin
						abort_now  = 1'b1;
						nxt_sub    = wsc_pkg::SUB_CONFIGURE;
						nxt_line   = wsc_pkg::RST_IRQ_LINE;
						nxt_ev_int = wsc_pkg::RST_EV_INT;
						nxt_top    = wsc_pkg::RST_TOP_LEVEL;
						nxt_ready  = 1'b0;
					end
					wsc_pkg::OP_ASSIGN_IRQ: begin
						nxt_line = cmd_i.arg[wsc_pkg::IRQ_LINE_W-1:0];
					end
					wsc_pkg::OP_ASYNC_MODE: begin
						if (async_hit) begin
							nxt_ev_int = 1'b1;
						end else begin
							nxt_rsp.err  = 1'b1;
							nxt_rsp.code = wsc_pkg::ERR_ASYNC;
						end
					end
					wsc_pkg::OP_BEGIN_NORMAL: begin
						nxt_sub   = wsc_pkg::SUB_NORMAL;
						nxt_ready = 1'b1;
						nxt_top   = cmd_i.arg[wsc_pkg::TOP_LEVEL_BIT];
					end
					default: begin
						nxt_rsp.err  = 1'b1;
						nxt_rsp.code = wsc_pkg::ERR_STATE;
					end
				endcase
			end
		end
	end

	// Interrupt request: event wins over acknowledge; zero line and abort win over all
	always_comb begin
		nxt_irq = irq_ff;
		if (irq_ack_i) begin
			nxt_irq = 1'b0;
		end
		if (event_i && ev_int_ff && (line_ff != '0)) begin
			nxt_irq = 1'b1;
		end
		// A pending request must not survive a line reassigned to zero
		if (nxt_line == '0) begin
			nxt_irq = 1'b0;
		end
		if (abort_now) begin
			nxt_irq = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sub_ff    <= wsc_pkg::SUB_CONFIGURE;
			rsp_ff    <= '0;
			line_ff   <= wsc_pkg::RST_IRQ_LINE;
			ev_int_ff <= wsc_pkg::RST_EV_INT;
			top_ff    <= wsc_pkg::RST_TOP_LEVEL;
			ready_ff  <= 1'b0;
			irq_ff    <= 1'b0;
		end else begin
			sub_ff    <= nxt_sub;
			rsp_ff    <= nxt_rsp;
			line_ff   <= nxt_line;
			ev_int_ff <= nxt_ev_int;
			top_ff    <= nxt_top;
			ready_ff  <= nxt_ready;
			irq_ff    <= nxt_irq;
		end
	end

	assign done_o      = rsp_ff.done;
	assign err_o       = rsp_ff.err;
	assign err_code_o  = rsp_ff.code;
	assign normal_o    = (sub_ff == wsc_pkg::SUB_NORMAL);
	assign ws_ready_o  = ready_ff;
	assign irq_line_o  = line_ff;
	assign ev_int_o    = ev_int_ff;
	assign top_level_o = top_ff;
	assign irq_o       = irq_ff;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence cfg_cmd_s(wsc_pkg::wsc_op_e op);
		cmd_valid_i && !normal_o && cmd_i.op == op;
	endsequence

	sequence normal_cmd_s;
		cmd_valid_i && normal_o;
	endsequence

	abort_restore_a: assert property (
		cfg_cmd_s(wsc_pkg::OP_ABORT_NORMAL) |=> !normal_o && irq_line_o == '0
			&& !top_level_o && !ev_int_o && !ws_ready_o && done_o && !err_o)
		else $error("abort did not restore default configuration");

	abort_irq_a: assert property (
		cfg_cmd_s(wsc_pkg::OP_ABORT_NORMAL) |=> !irq_o)
		else $error("interrupt still asserted after abort");

	assign_line_a: assert property (
		cfg_cmd_s(wsc_pkg::OP_ASSIGN_IRQ) |=>
			irq_line_o == $past(cmd_i.arg[wsc_pkg::IRQ_LINE_W-1:0]) && !err_o)
		else $error("assigned interrupter line not stored");

	zero_line_a: assert property (
		irq_line_o == '0 |-> !irq_o)
		else $error("interrupt raised with line zero");

	irq_raise_a: assert property (
		event_i && ev_int_o && irq_line_o != '0 && !cmd_valid_i |=> irq_o)
		else $error("event on assigned line did not interrupt");

	async_mode_a: assert property (
		cfg_cmd_s(wsc_pkg::OP_ASYNC_MODE) |=>
			(err_o == !$past(async_hit)) && (ev_int_o == (!err_o || $past(ev_int_o))))
		else $error("asynchronous mode check wrong");

	begin_normal_a: assert property (
		cfg_cmd_s(wsc_pkg::OP_BEGIN_NORMAL) |=> normal_o && ws_ready_o ##1 normal_o)
		else $error("begin normal did not enter normal operation");

	ready_flags_a: assert property (
		$rose(normal_o) |-> ws_ready_o)
		else $error("readiness flags not set on entering normal");

	top_level_a: assert property (
		cfg_cmd_s(wsc_pkg::OP_BEGIN_NORMAL) |=>
			top_level_o == $past(cmd_i.arg[wsc_pkg::TOP_LEVEL_BIT]))
		else $error("top level bit not captured");

	normal_reject_a: assert property (
		normal_cmd_s |=> err_o && err_code_o == wsc_pkg::ERR_STATE
			&& $stable(irq_line_o) && $stable(top_level_o) && normal_o)
		else $error("command in normal operation not rejected");

	sequence irq_clear_s;
		irq_o && irq_ack_i && !event_i;
	endsequence

	irq_ack_a: assert property (
		irq_clear_s |=> !irq_o)
		else $error("acknowledge did not clear interrupt");

	irq_hold_a: assert property (
		irq_o && !irq_ack_i && !cmd_valid_i |=> irq_o)
		else $error("interrupt dropped without acknowledge");

	ev_disabled_a: assert property (
		!irq_o && !ev_int_o |=> !irq_o)
		else $error("interrupt raised with events disabled");

	cmd_answer_a: assert property (
		cmd_valid_i |=> done_o)
		else $error("command not answered");

	idle_rsp_a: assert property (
		!cmd_valid_i |=> !done_o && !err_o && err_code_o == wsc_pkg::ERR_NONE)
		else $error("response without command");

	normal_ready_a: assert property (
		normal_o |-> ws_ready_o)
		else $error("readiness flags lost in normal operation");
endmodule : wsc_config_cmd
`default_nettype wire

// file: wsc_cmdr.sv
// Commander model that issues word-serial configuration commands
`default_nettype none
module wsc_cmdr (
	input  wire logic               core_clk_i,
	input  wire logic               sys_rst_i,
	input  wire logic               go_i,
	input  wire wsc_pkg::wsc_cmd_s  req_i,
	output wsc_pkg::wsc_cmd_s       cmd_o,
	output logic                    cmd_valid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// One-cycle strobe per command; idle argument is inverted so it is never stale
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cmd_valid_o <= 1'b0;
			cmd_o       <= '1;
		end else begin
			cmd_valid_o <= go_i;
			cmd_o       <= go_i ? req_i : ~req_i;
		end
	end
endmodule // wsc_cmdr
`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the configuration command decoder
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic              core_clk_i = 1'b0;
	logic              sys_rst_i = 1'b1;
	logic              go = 1'b0;
	logic              event_i = 1'b0;
	logic              irq_ack_i = 1'b0;
	wsc_pkg::wsc_cmd_s req = '0;
	wsc_pkg::wsc_cmd_s cmd;
	logic              vld, done, err, nrm, rdy, ev, top, irq;
	logic [3:0]        code;
	logic [2:0]        line, m_line;
	logic              m_norm, m_ev, m_top, m_irq;
	logic [31:0]       seed = 32'hC1355DF3;
	int                error_cnt = 0;
	int                compares = 0;

	initial begin
		forever #12.5 core_clk_i = ~core_clk_i;
	end

	wsc_cmdr u_cmdr (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .go_i(go),
		.req_i(req), .cmd_o(cmd), .cmd_valid_o(vld));
	wsc_config_cmd u_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.cmd_valid_i(vld), .cmd_i(cmd), .event_i(event_i), .irq_ack_i(irq_ack_i),
		.done_o(done), .err_o(err), .err_code_o(code), .normal_o(nrm), .ws_ready_o(rdy),
		.irq_line_o(line), .ev_int_o(ev), .top_level_o(top), .irq_o(irq));

	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("Compares %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic rst();
		@(posedge core_clk_i);
		sys_rst_i <= 1'b1;
		repeat (12) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		{m_norm, m_line, m_ev, m_top, m_irq} = '0;
	endtask

	task automatic st();
		@(negedge core_clk_i);
		chk(nrm, m_norm);
		chk(rdy, m_norm);
		chk(line, m_line);
		chk(ev, m_ev);
		chk(top, m_top);
		chk(irq, m_irq);
		chk(done, 1'b0);
		chk(err, 1'b0);
	endtask

	task automatic do_cmd(input wsc_pkg::wsc_op_e op, input logic [15:0] arg);
		logic [3:0] e;
		e = wsc_pkg::ERR_NONE;
		if (m_norm)
			e = wsc_pkg::ERR_STATE;
		else if (op == wsc_pkg::OP_ABORT_NORMAL)
			{m_line, m_ev, m_top, m_irq} = '0;
		else if (op == wsc_pkg::OP_ASSIGN_IRQ) begin
			m_line = arg[2:0];
			m_irq  = m_irq && (arg[2:0] != 3'h0);
		end
		else if (op == wsc_pkg::OP_ASYNC_MODE && (arg & 16'h000F) == 16'h0008)
			m_ev = 1'b1;
		else if (op == wsc_pkg::OP_ASYNC_MODE)
			e = wsc_pkg::ERR_ASYNC;
		else
			{m_norm, m_top} = {1'b1, arg[8]};
		@(posedge core_clk_i);
		go  <= 1'b1;
		req <= '{op, arg};
		@(posedge core_clk_i);
		go <= 1'b0;
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		chk(done, 1'b1);
		chk(err, e != 0);
		chk(code, e);
		st();
	endtask

	task automatic pulse(input logic e, input logic a);
		@(posedge core_clk_i);
		event_i   <= e;
		irq_ack_i <= a;
		@(posedge core_clk_i);
		event_i   <= 1'b0;
		irq_ack_i <= 1'b0;
		m_irq = (m_irq & !a) | (e & m_ev & (m_line != 0));
		st();
	endtask

	initial begin
		rst();
		st();
		pulse(1'b1, 1'b0);
		for (int i = 0; i < 6; i++) begin
			do_cmd(wsc_pkg::OP_ASYNC_MODE, (i < 2) ? 16'h0008 : rnd());
			do_cmd(wsc_pkg::OP_ASSIGN_IRQ, rnd());
			pulse(1'b1, 1'b0);
			pulse(seed[3], 1'b1);
		end
		do_cmd(wsc_pkg::OP_ASSIGN_IRQ, 16'h0005);
		pulse(1'b1, 1'b0);
		do_cmd(wsc_pkg::OP_ASSIGN_IRQ, 16'h0000);
		do_cmd(wsc_pkg::OP_ASSIGN_IRQ, 16'h0005);
		pulse(1'b1, 1'b0);
		do_cmd(wsc_pkg::OP_ABORT_NORMAL, rnd());
		do_cmd(wsc_pkg::OP_ASSIGN_IRQ, 16'h0003);
		pulse(1'b1, 1'b0);
		for (int j = 0; j < 2; j++) begin
			do_cmd(wsc_pkg::OP_BEGIN_NORMAL, j ? (rnd() | 16'h0100) : (rnd() & 16'hFEFF));
			for (int k = 0; k < 4; k++)
				do_cmd(wsc_pkg::wsc_op_e'(k), rnd());
			rst();
		end
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge core_clk_i);
		error_cnt++;
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
